// file: lsu_shift_unit.sv
`timescale 1ns/1ps
module lsu_shift_unit
  import lsu_pkg::*;
#(
  parameter int DATA_W = LSU_DATA_W // register width; only 32 is served
) (
  input  wire logic        clk,      // 10 MHz processor clock
  input  wire logic        sys_rst,  // synchronous reset, active high
  input  wire lsu_req_t    req,      // decoded instruction and operand
  output lsu_rsp_t         rsp,      // registered write-back
  output logic [3:0]       src_num   // register number the file must read
);
  // the opcode map is fixed at 32 bits, so refuse anything else
  if (DATA_W != 32) begin : g_bad_width
    $error("lsu_shift_unit serves only a 32-bit register");
  end

  lsu_rsp_t          rsp_reg;   // output register
  lsu_rsp_t          rsp_next;  // its next value
  logic [3:0]        num_reg;   // registered read address
  wire  [3:0]        reg_num;   // register field of the opcode
  wire               is_grp;    // top nibble selects the shift group
  wire  [7:0]        low;       // function byte
  wire               hit;       // a logical shift is requested
  wire               one_bit;   // one-bit form, writes the flag
  wire  [31:0]       d;         // operand alias
  wire  [31:0]       result;    // selected shift result
  wire               new_flag;  // flag after execution

  // source and destination are the same field
  assign reg_num = req.opcode[LSU_REG_NUM_HI:LSU_REG_NUM_LO];
  assign is_grp  = req.opcode[15:12] == LSU_GROUP;
  assign low     = req.opcode[7:0];
  assign d       = req.operand;

  // decode: any unknown function byte is ignored, so no write occurs
  assign hit = req.valid && is_grp &&
               (low == LSU_OP_SHL1 || low == LSU_OP_SHL2 || low == LSU_OP_SHL8 ||
                low == LSU_OP_SHL16 || low == LSU_OP_SHR1 || low == LSU_OP_SHR2 ||
                low == LSU_OP_SHR8 || low == LSU_OP_SHR16);
  assign one_bit = (low == LSU_OP_SHL1) || (low == LSU_OP_SHR1);

  // shift selection; vacated bits are zero in every form
  assign result =
    (low == LSU_OP_SHL1)  ? {d[30:0], 1'b0}   :
    (low == LSU_OP_SHL2)  ? {d[29:0], 2'b00}  :
    (low == LSU_OP_SHL8)  ? {d[23:0], 8'h00}  :
    (low == LSU_OP_SHL16) ? {d[15:0], 16'h0000} :
    (low == LSU_OP_SHR1)  ? {1'b0, d[31:1]}   :
    (low == LSU_OP_SHR2)  ? {2'b00, d[31:2]}  :
    (low == LSU_OP_SHR8)  ? {8'h00, d[31:8]}  :
    {16'h0000, d[31:16]};

  // shifted-out bit for one-bit forms; multi-bit forms keep the flag
  assign new_flag = (low == LSU_OP_SHL1) ? d[31] :
                    (low == LSU_OP_SHR1) ? d[0]  :
                    req.flag;

  // next answer: written back exactly one cycle after the request
  always_comb begin
    rsp_next         = '0;
    rsp_next.wr_en   = hit;
    rsp_next.wr_num  = reg_num;
    rsp_next.wr_data = hit ? result : LSU_DATA_RST;
    rsp_next.flag    = hit ? new_flag : req.flag;
    rsp_next.flag_we = hit && one_bit;
  end

  // output and read-address registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsp_reg <= '0;
      num_reg <= 4'h0;
    end else begin
      rsp_reg <= rsp_next;
      num_reg <= reg_num;
    end
  end

  assign rsp     = rsp_reg;
  assign src_num = num_reg;

  // request shapes, one per kind of function byte; declared once so that
  // the checks below read as plain cause and effect
  sequence s_left_one_req;
    hit && low == LSU_OP_SHL1;
  endsequence

  // right by one, the other flag-writing form
  sequence s_right_one_req;
    hit && low == LSU_OP_SHR1;
  endsequence

  // any of the six multi-bit forms
  sequence s_multi_req;
    hit && !one_bit;
  endsequence

  // an opcode the unit must leave alone
  sequence s_refused_req;
    req.valid && !hit;
  endsequence

  // answer shapes, seen one edge after the request
  sequence s_left_one_done;
    rsp.flag_we && rsp.flag == $past(d[31]) && rsp.wr_data == {$past(d[30:0]), 1'b0};
  endsequence

  // zero enters at the top, old low bit lands in the flag
  sequence s_right_one_done;
    rsp.flag_we && rsp.flag == $past(d[0]) && rsp.wr_data == {1'b0, $past(d[31:1])};
  endsequence

  // multi-bit forms pass the incoming flag through untouched
  sequence s_flag_kept;
    !rsp.flag_we && rsp.flag == $past(req.flag);
  endsequence

  // nothing is written to the register file or the flag
  sequence s_no_write;
    !rsp.wr_en && !rsp.flag_we;
  endsequence

  // write-back lands one cycle after an accepted shift, to the same register
  a_one_cycle_wb: assert property (@(posedge clk) disable iff (sys_rst)
    hit |=> rsp.wr_en && rsp.wr_num == $past(reg_num))
    else $error("shift did not write back in one cycle");

  // left by one: data and flag checked together, both come from one edge
  a_left_one_flag: assert property (@(posedge clk) disable iff (sys_rst)
    s_left_one_req |=> s_left_one_done)
    else $error("left by one result or flag wrong");

  // right by one: the whole word, not only the filled top bit
  a_right_one_flag: assert property (@(posedge clk) disable iff (sys_rst)
    s_right_one_req |=> s_right_one_done)
    else $error("right by one result or flag wrong");

  // left by two
  a_left_two: assert property (@(posedge clk) disable iff (sys_rst)
    hit && low == LSU_OP_SHL2 |=> rsp.wr_data == ($past(d) << 2))
    else $error("left by two wrong");

  // left by eight
  a_left_multi: assert property (@(posedge clk) disable iff (sys_rst)
    hit && low == LSU_OP_SHL8 |=> rsp.wr_data == ($past(d) << 8))
    else $error("left by eight wrong");

  // left by sixteen, vacated half first
  a_left_sixteen: assert property (@(posedge clk) disable iff (sys_rst)
    hit && low == LSU_OP_SHL16 |=> rsp.wr_data[15:0] == 16'h0000)
    else $error("left by sixteen low half not zero");

  // left by sixteen, the moved half as well
  a_left_sixteen_data: assert property (@(posedge clk) disable iff (sys_rst)
    hit && low == LSU_OP_SHL16 |=> rsp.wr_data == ($past(d) << 16))
    else $error("left by sixteen wrong");

  // right by two
  a_right_multi: assert property (@(posedge clk) disable iff (sys_rst)
    hit && low == LSU_OP_SHR2 |=> rsp.wr_data == ($past(d) >> 2))
    else $error("right by two wrong");

  // right by eight
  a_right_eight: assert property (@(posedge clk) disable iff (sys_rst)
    hit && low == LSU_OP_SHR8 |=> rsp.wr_data == ($past(d) >> 8))
    else $error("right by eight wrong");

  // right by sixteen, vacated half first
  a_right_sixteen: assert property (@(posedge clk) disable iff (sys_rst)
    hit && low == LSU_OP_SHR16 |=> rsp.wr_data[31:16] == 16'h0000)
    else $error("right by sixteen high half not zero");

  // right by sixteen, the moved half as well
  a_right_sixteen_data: assert property (@(posedge clk) disable iff (sys_rst)
    hit && low == LSU_OP_SHR16 |=> rsp.wr_data == ($past(d) >> 16))
    else $error("right by sixteen wrong");

  // multi-bit forms drop the shifted-out bits and leave the flag alone
  a_multi_keeps_flag: assert property (@(posedge clk) disable iff (sys_rst)
    s_multi_req |=> s_flag_kept)
    else $error("multi-bit shift touched the flag");

  // read address follows the register field, whether or not it is a shift
  a_reg_field: assert property (@(posedge clk) disable iff (sys_rst)
    req.valid |=> src_num == $past(req.opcode[11:8]))
    else $error("register number not from bits 11..8");

  // the written register is the one the opcode named
  a_wb_num: assert property (@(posedge clk) disable iff (sys_rst)
    hit |=> rsp.wr_num == $past(req.opcode[11:8]))
    else $error("write-back went to the wrong register");

  // foreign opcodes must not disturb the register file or the flag
  a_refused_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    s_refused_req |=> s_no_write)
    else $error("refused opcode caused a write");

  // a write-back only ever follows an accepted shift; no stray pulses
  a_no_stray_write: assert property (@(posedge clk) disable iff (sys_rst)
    !hit |=> !rsp.wr_en && rsp.wr_data == LSU_DATA_RST)
    else $error("write-back without a shift");

  // reset empties the answer register, so nothing lands after it
  a_reset_clears: assert property (@(posedge clk)
    sys_rst |=> !rsp.wr_en && !rsp.flag_we && rsp.wr_data == LSU_DATA_RST &&
      rsp.flag == LSU_FLAG_RST && src_num == 4'h0)
    else $error("reset did not clear the answer");
endmodule

// file: lsu_pkg.sv
package lsu_pkg;
  localparam int          LSU_DATA_W     = 32;           // general register width
  localparam int          LSU_REG_NUM_LO = 8;            // register field low bit
  localparam int          LSU_REG_NUM_HI = 11;           // register field high bit
  localparam logic [3:0]  LSU_GROUP      = 4'h4;         // opcode bits 15..12
  localparam logic [7:0]  LSU_OP_SHL1    = 8'h00;        // low byte, left by one
  localparam logic [7:0]  LSU_OP_SHL2    = 8'h08;        // left by two
  localparam logic [7:0]  LSU_OP_SHL8    = 8'h18;        // left by eight
  localparam logic [7:0]  LSU_OP_SHL16   = 8'h28;        // left by sixteen
  localparam logic [7:0]  LSU_OP_SHR1    = 8'h01;        // right by one
  localparam logic [7:0]  LSU_OP_SHR2    = 8'h09;        // right by two
  localparam logic [7:0]  LSU_OP_SHR8    = 8'h19;        // right by eight
  localparam logic [7:0]  LSU_OP_SHR16   = 8'h29;        // right by sixteen
  localparam logic [31:0] LSU_DATA_RST   = 32'h00000000; // result reset value
  localparam logic        LSU_FLAG_RST   = 1'h0;         // flag reset value

  // request from the decoder: opcode plus the register operand it read
  typedef struct packed {
    logic        valid;   // opcode presented this cycle
    logic [15:0] opcode;  // instruction word
    logic [31:0] operand; // contents of the addressed register
    logic        flag;    // condition flag before execution
  } lsu_req_t;

  // answer to the register file and flag
  typedef struct packed {
    logic        wr_en;   // write back this cycle
    logic [3:0]  wr_num;  // register written
    logic [31:0] wr_data; // shifted value
    logic        flag;    // condition flag after execution
    logic        flag_we; // flag is being written
  } lsu_rsp_t;
endpackage

// file: lsu_regfile_model.sv
`timescale 1ns/1ps
module lsu_regfile_model
  import lsu_pkg::*;
(
  input  wire logic        clk,   // processor clock
  input  wire logic        issue, // decoder presents an opcode
  input  wire logic [15:0] op,    // instruction word to present
  input  wire lsu_rsp_t    rsp,   // write-back from the unit
  output lsu_req_t         req    // request toward the unit
);
  logic [31:0] regs [16]; // general registers, preloaded by the bench
  logic        flag_reg;  // condition flag
  // bypass a result still on its way, so back-to-back shifts see fresh data
  wire         fwd = rsp.wr_en && rsp.wr_num == op[11:8];
  // operand comes from the register named in bits 11..8, same cycle
  assign req = '{issue, op, fwd ? rsp.wr_data : regs[op[11:8]], rsp.flag_we ? rsp.flag : flag_reg};
  // write-back lands in the register the unit names
  always @(posedge clk) begin
    if (rsp.wr_en) regs[rsp.wr_num] <= rsp.wr_data;
    if (rsp.flag_we) flag_reg <= rsp.flag;
  end
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top import lsu_pkg::*; ;
  logic        clk = 0, sys_rst = 1, issue = 0; // clock, reset, opcode strobe
  logic [15:0] op = 16'h0000;                   // opcode handed to the model
  lsu_req_t    req;                             // model to unit
  lsu_rsp_t    rsp;                             // unit to model
  int          mismatches = 0, samples_checked = 0;
  logic [3:0]  src_num;                         // read address from the unit
  logic [7:0]  codes [8] = '{LSU_OP_SHL1, LSU_OP_SHL2, LSU_OP_SHL8, LSU_OP_SHL16,
                             LSU_OP_SHR1, LSU_OP_SHR2, LSU_OP_SHR8, LSU_OP_SHR16};
  lsu_shift_unit i_dut (.clk(clk), .sys_rst(sys_rst), .req(req), .rsp(rsp), .src_num(src_num));
  lsu_regfile_model i_model (.clk(clk), .issue(issue), .op(op), .rsp(rsp), .req(req));
  initial forever #50 clk = ~clk;
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  // {flag, result} as the shift should leave them
  function automatic logic [32:0] expect_of(logic [7:0] c, logic [31:0] v, logic f);
    case (c)
      LSU_OP_SHL1:  return {v, 1'h0};
      LSU_OP_SHR1:  return {v[0], 1'h0, v[31:1]};
      LSU_OP_SHL2:  return {f, v << 2};
      LSU_OP_SHL8:  return {f, v << 8};
      LSU_OP_SHL16: return {f, v << 16};
      LSU_OP_SHR2:  return {f, v >> 2};
      LSU_OP_SHR8:  return {f, v >> 8};
      default:      return {f, v >> 16};
    endcase
  endfunction
  // two idle edges let any write-back land before the preload
  task automatic run(logic [15:0] o, logic [31:0] v, logic f, logic hold);
    repeat (2) @(posedge clk);
    i_model.regs[o[11:8]] <= v;
    i_model.flag_reg <= f;
    op <= o;
    issue <= 1'h1;
    @(posedge clk);
    issue <= hold;
    #1;
  endtask
  task automatic t_codes;
    logic [32:0] e;
    for (int i = 0; i < 16; i++) begin
      run({4'h4, 4'(i), codes[i % 8]}, i < 8 ? 32'h80000001 : 32'h7FFFFFFE, i >= 8, 1'h0);
      e = expect_of(codes[i % 8], i < 8 ? 32'h80000001 : 32'h7FFFFFFE, i >= 8);
      chk("src", 32'(i[3:0]), 32'(src_num));
      chk("data", e[31:0], rsp.wr_data);
      chk("ctl", 32'({e[32], codes[i % 8][7:1] == 7'h00, 5'h10 | i[3:0]}),
          32'({rsp.flag, rsp.flag_we, rsp.wr_en, rsp.wr_num}));
    end
    $display("test codes done");
  endtask
  task automatic t_back_to_back;
    repeat (2) @(posedge clk);
    i_model.regs[5] <= 32'h12345678;
    i_model.flag_reg <= 1'h1;
    op <= 16'h4508;
    issue <= 1'h1;
    @(posedge clk);
    op <= 16'h4519;
    #1;
    chk("first", 32'h48D159E0, rsp.wr_data);
    @(posedge clk);
    issue <= 1'h0;
    #1;
    chk("second", 32'h0048D159, rsp.wr_data);
    chk("ctl2", 32'h00000055, 32'({rsp.flag, rsp.flag_we, rsp.wr_en, rsp.wr_num}));
    @(posedge clk);
    #1;
    chk("reg5", 32'h0048D159, i_model.regs[5]);
    $display("test back_to_back done");
  endtask
  // a shift issued while reset is held must leave nothing behind
  task automatic t_reset;
    repeat (2) @(posedge clk);
    i_model.regs[3] <= 32'h80000001;
    op <= 16'h4300;
    issue <= 1'h1;
    sys_rst <= 1'h1;
    @(posedge clk);
    issue <= 1'h0;
    sys_rst <= 1'h0;
    #1;
    chk("rst_ctl", 32'h0, 32'({rsp.wr_en, rsp.flag_we, rsp.flag, rsp.wr_num, src_num}));
    chk("rst_data", 32'h0, rsp.wr_data);
    $display("test reset done");
  endtask
  task automatic t_refused;
    run(16'h4320, 32'h80000001, 1'h0, 1'h0);
    chk("arith", 32'h0, 32'({rsp.flag_we, rsp.wr_en}));
    run(16'h5300, 32'h80000001, 1'h0, 1'h0);
    chk("group", 32'h0, 32'({rsp.flag_we, rsp.wr_en}));
    $display("test refused done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // about 70 cycles of work; cut a hang well after that
  initial begin
    #40000;
    mismatches++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'h0;
    t_codes();
    t_back_to_back();
    t_reset();
    t_refused();
    conclude();
  end
endmodule
